// [core/pci_agent_pkg.sv]
package pci_agent_pkg;

    // bus commands as they appear on the command/enable pins
    localparam logic [3:0] CMD_MEM_RD = 4'h6;
    localparam logic [3:0] CMD_MEM_WR = 4'h7;
    localparam logic [3:0] CMD_CFG_RD = 4'hA;
    localparam logic [3:0] CMD_CFG_WR = 4'hB;
    localparam logic [3:0] CMD_MEM_RD_MULT = 4'hC;
    localparam logic [3:0] CMD_MEM_RD_LINE = 4'hE;
    localparam logic [3:0] CMD_MEM_WR_INV = 4'hF;

    // configuration space dword indexes
    localparam logic [5:0] CFG_IDX_ID = 6'h00;
    localparam logic [5:0] CFG_IDX_CTRL = 6'h01;
    // identity word, value is arbitrary
    localparam logic [31:0] CFG_ID_VALUE = 32'h5A5A_1234;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int CTRL_MEM_EN_BIT = 1;

    // memory window defaults
    localparam logic [31:0] MEM_BASE_DEF = 32'h8000_0000;
    localparam int WIN_BITS_DEF = 12;

    // data path shape
    localparam int DATA_W = 64;
    localparam int BE_W = 8;
    localparam int FIFO_DEPTH = 4;

    typedef enum logic [1:0] {S_IDLE, S_RDWAIT, S_DATA, S_TURN} tgt_state_t;

endpackage

// [core/pci_target.sv]
`timescale 1ns/1ps

// small synchronous fifo with honest full and empty
module fifo_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic do_push;
    logic do_pop;

    // handshakes
    assign in_ready = (count != DEPTH_C);
    assign out_valid = (count != '0);
    assign do_push = in_valid && in_ready;
    assign do_pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    // storage
    always_ff @(posedge sys_clk) begin
        if (do_push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= (wr_ptr == LAST_C) ? '0 : wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= (rd_ptr == LAST_C) ? '0 : rd_ptr + 1'b1;
            end
            if (do_push && !do_pop) begin
                count <= count + 1'b1;
            end else if (do_pop && !do_push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// target-only bus agent: memory writes flow into a fifo, reads return status
module pci_target #(
    parameter logic [31:0] MEM_BASE = pci_agent_pkg::MEM_BASE_DEF,
    parameter int WIN_BITS = pci_agent_pkg::WIN_BITS_DEF,
    parameter int FIFO_DEPTH = pci_agent_pkg::FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic frame_n,
    input wire logic irdy_n,
    input wire logic idsel,
    input wire logic req64_n,
    input wire logic [pci_agent_pkg::DATA_W-1:0] ad_in,
    input wire logic [pci_agent_pkg::BE_W-1:0] cbe_n_in,
    output logic [pci_agent_pkg::DATA_W-1:0] ad_out,
    output logic ad_lo_oe_n,
    output logic ad_hi_oe_n,
    output logic devsel_n_out,
    output logic devsel_oe_n,
    output logic trdy_n_out,
    output logic trdy_oe_n,
    output logic ack64_n_out,
    output logic ack64_oe_n,
    output logic par_out,
    output logic par_oe_n,
    output logic par64_out,
    output logic par64_oe_n,
    output logic wr_valid,
    input wire logic wr_ready,
    output logic [pci_agent_pkg::DATA_W-1:0] wr_data,
    output logic [pci_agent_pkg::BE_W-1:0] wr_be,
    output logic mem_enable
);
    import pci_agent_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking // assertion clock
    default disable iff (!nrst);
    localparam int FW = DATA_W + BE_W;

    tgt_state_t state;
    tgt_state_t next_state;
    logic frame_prev;
    logic [31:0] addr_q;
    logic is_wr;
    logic is_cfg;
    logic xfer64;
    logic [31:0] cfg_ctrl;
    logic [31:0] push_count;
    logic addr_phase;
    logic hit_mem;
    logic hit_cfg;
    logic claim;
    logic trdy_ok;
    logic done;
    logic push;
    logic fifo_ready;
    logic [FW-1:0] fifo_in;
    logic [FW-1:0] fifo_out;
    logic [31:0] rd_lo;
    logic [BE_W-1:0] be_act;

    function automatic logic is_mem_rd(input logic [3:0] c);
        return (c == CMD_MEM_RD) || (c == CMD_MEM_RD_MULT) || (c == CMD_MEM_RD_LINE);
    endfunction

    function automatic logic is_mem_wr(input logic [3:0] c);
        return (c == CMD_MEM_WR) || (c == CMD_MEM_WR_INV);
    endfunction

    // merge a dword under active-high byte enables
    function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    // address phase of a granted master: FRAME low after it was high; never initiates
    assign addr_phase = (state == S_IDLE) && frame_prev && !frame_n;
    // lower AD holds the address, lower C/BE the command
    assign hit_mem = cfg_ctrl[CTRL_MEM_EN_BIT]
                     && (is_mem_rd(cbe_n_in[3:0]) || is_mem_wr(cbe_n_in[3:0]))
                     && (ad_in[31:WIN_BITS] == MEM_BASE[31:WIN_BITS]);
    assign hit_cfg = idsel && (ad_in[1:0] == 2'b00)
                     && ((cbe_n_in[3:0] == CMD_CFG_RD) || (cbe_n_in[3:0] == CMD_CFG_WR));
    assign claim = addr_phase && (hit_mem || hit_cfg);

    // target ready: writes into the fifo stall on back-pressure
    assign trdy_ok = (is_wr && !is_cfg) ? fifo_ready : 1'b1;
    assign done = (state == S_DATA) && !irdy_n && trdy_ok;
    assign push = done && is_wr && !is_cfg;

    // active-high enables; upper lanes only in a 64-bit transfer
    assign be_act = {xfer64 ? ~cbe_n_in[7:4] : 4'h0, ~cbe_n_in[3:0]};
    assign fifo_in = {be_act, xfer64 ? ad_in[63:32] : 32'h0, ad_in[31:0]};

    // frame history for address phase detection
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            frame_prev <= 1'b1;
        end else begin
            frame_prev <= frame_n;
        end
    end

    // transaction sequencer
    always_comb begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (claim) begin
                    next_state = is_mem_wr(cbe_n_in[3:0]) || (cbe_n_in[3:0] == CMD_CFG_WR)
                                 ? S_DATA : S_RDWAIT;
                end
            end
            S_RDWAIT: begin
                next_state = S_DATA;
            end
            S_DATA: begin
                if (done && frame_n) begin
                    next_state = S_TURN;
                end
            end
            S_TURN: begin
                next_state = S_IDLE;
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= S_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // capture of the address phase
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            addr_q <= 32'h0000_0000;
            is_wr <= 1'b0;
            is_cfg <= 1'b0;
            xfer64 <= 1'b0;
        end else if (claim) begin
            addr_q <= ad_in[31:0];
            is_wr <= is_mem_wr(cbe_n_in[3:0]) || (cbe_n_in[3:0] == CMD_CFG_WR);
            is_cfg <= hit_cfg;
            xfer64 <= !req64_n && !hit_cfg;
        end
    end

    // configuration control word; bit one enables memory decode
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_ctrl <= CTRL_RESET;
        end else if (done && is_cfg && is_wr && (addr_q[7:2] == CFG_IDX_CTRL)) begin
            cfg_ctrl <= merge_be(cfg_ctrl, ad_in[31:0], be_act[3:0]);
        end
    end

    // count of data phases accepted into the fifo
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            push_count <= 32'h0000_0000;
        end else if (push) begin
            push_count <= push_count + 32'h0000_0001;
        end
    end

    // read data source
    always_comb begin
        rd_lo = push_count;
        if (is_cfg) begin
            case (addr_q[7:2])
                CFG_IDX_ID: rd_lo = CFG_ID_VALUE;
                CFG_IDX_CTRL: rd_lo = cfg_ctrl;
                default: rd_lo = 32'h0000_0000;
            endcase
        end
    end

    // read data register; upper dword mirrors the low word
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ad_out <= '0;
        end else begin
            ad_out <= {rd_lo, rd_lo};
        end
    end

    // parity follows read data one clock later
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            par_out <= 1'b0;
            par_oe_n <= 1'b1;
            par64_out <= 1'b0;
            par64_oe_n <= 1'b1;
        end else begin
            par_out <= ^{ad_out[31:0], cbe_n_in[3:0]};
            par_oe_n <= ad_lo_oe_n;
            par64_out <= ^{ad_out[63:32], cbe_n_in[7:4]};
            par64_oe_n <= ad_hi_oe_n;
        end
    end

    // pin drivers; enables are low while driving
    assign devsel_n_out = !((state == S_RDWAIT) || (state == S_DATA));
    assign devsel_oe_n = (state == S_IDLE);
    assign ack64_n_out = !(xfer64 && ((state == S_RDWAIT) || (state == S_DATA)));
    assign ack64_oe_n = (state == S_IDLE) || !xfer64;
    assign trdy_n_out = !((state == S_DATA) && trdy_ok);
    assign trdy_oe_n = (state == S_IDLE);
    assign ad_lo_oe_n = !((state == S_DATA) && !is_wr);
    assign ad_hi_oe_n = !((state == S_DATA) && !is_wr && xfer64);
    assign mem_enable = cfg_ctrl[CTRL_MEM_EN_BIT];

    fifo_buf #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
        .sys_clk(sys_clk), .nrst(nrst), .in_valid(push), .in_ready(fifo_ready),
        .in_data(fifo_in), .out_valid(wr_valid), .out_ready(wr_ready), .out_data(fifo_out)
    );

    assign wr_data = fifo_out[DATA_W-1:0];
    assign wr_be = fifo_out[FW-1:DATA_W];
    // ack64 never asserted without devsel
    property p_ack_with_devsel;
        (!ack64_oe_n && !ack64_n_out) |-> (!devsel_oe_n && !devsel_n_out);
    endproperty
    a_ack_with_devsel: assert property (p_ack_with_devsel) else $error("ack64 alone");
    // ack64 rises with devsel exactly when req64 was seen at a memory claim
    property p_ack_timing;
        (claim && hit_mem && !req64_n) |=> (!devsel_n_out && !ack64_n_out);
    endproperty
    a_ack_timing: assert property (p_ack_timing) else $error("ack64 late");
    // claim drives devsel on the next clock
    property p_devsel_after_claim;
        claim |=> (!devsel_n_out && !devsel_oe_n);
    endproperty
    a_devsel_after_claim: assert property (p_devsel_after_claim) else $error("no devsel");
    // no config claim without idsel
    property p_cfg_needs_idsel;
        (addr_phase && !idsel && !hit_mem) |=> devsel_n_out;
    endproperty
    a_cfg_needs_idsel: assert property (p_cfg_needs_idsel) else $error("no idsel");
    // read turnaround: no AD drive in the clock after the address phase
    property p_read_turnaround;
        (state == S_RDWAIT) |-> (ad_lo_oe_n ##1 (!ad_lo_oe_n && !trdy_n_out));
    endproperty
    a_read_turnaround: assert property (p_read_turnaround) else $error("read timing");
    // parity one clock after driven read data, even over AD and enables
    property p_read_parity;
        !ad_lo_oe_n |=> (!par_oe_n
                         && (par_out == ^{$past(ad_out[31:0]), $past(cbe_n_in[3:0])}));
    endproperty
    a_read_parity: assert property (p_read_parity) else $error("bad parity");
    // upper lanes stay undriven outside 64-bit transfers
    property p_upper_quiet;
        !xfer64 |-> (ad_hi_oe_n && ack64_oe_n && (!push || (fifo_in[FW-1:FW-4] == 4'h0)));
    endproperty
    a_upper_quiet: assert property (p_upper_quiet) else $error("upper lanes used");
    // a completed final phase deasserts devsel and trdy on the next clock and stops driving devsel one clock after that
    property p_final_phase;
        (done && frame_n) |=> (devsel_n_out && trdy_n_out && !devsel_oe_n) ##1 devsel_oe_n;
    endproperty
    a_final_phase: assert property (p_final_phase) else $error("final phase open");
    // an accepted write reaches the fifo with its lane enables
    property p_write_lanes;
        push |-> (!irdy_n && !trdy_n_out && (fifo_in[DATA_W +: 4] == ~cbe_n_in[3:0]));
    endproperty
    a_write_lanes: assert property (p_write_lanes) else $error("bad write push");
    // a held-off write keeps trdy deasserted while the fifo is full
    property p_backpressure;
        ((state == S_DATA) && is_wr && !is_cfg && !fifo_ready) |-> (trdy_n_out && !push);
    endproperty
    a_backpressure: assert property (p_backpressure) else $error("push while full");
endmodule

// [verification/pci_master_model.sv]
`timescale 1ns/1ps

// behavioural bus master facing the target's pins
module pci_master_model (
    input wire logic sys_clk,
    output logic frame_n,
    output logic irdy_n,
    output logic idsel,
    output logic req64_n,
    output logic [63:0] ad_in,
    output logic [7:0] cbe_n_in,
    input wire logic [63:0] ad_out,
    input wire logic ad_lo_oe_n,
    input wire logic ad_hi_oe_n,
    input wire logic devsel_n_out,
    input wire logic devsel_oe_n,
    input wire logic trdy_n_out,
    input wire logic trdy_oe_n,
    input wire logic ack64_n_out,
    input wire logic ack64_oe_n,
    input wire logic par_out,
    input wire logic par_oe_n
);
    logic [63:0] m_ad;
    logic m_oe;
    logic req_n;
    logic gnt_n;

    // wire level: target lanes win, released lanes show the inverse of the last value
    always_comb begin
        ad_in[31:0] = !ad_lo_oe_n ? ad_out[31:0] : (m_oe ? m_ad[31:0] : ~m_ad[31:0]);
        ad_in[63:32] = !ad_hi_oe_n ? ad_out[63:32] : (m_oe ? m_ad[63:32] : ~m_ad[63:32]);
    end

    initial begin
        frame_n = 1'b1;
        irdy_n = 1'b1;
        idsel = 1'b0;
        req64_n = 1'b1;
        cbe_n_in = 8'hFF;
        m_ad = 64'h0;
        m_oe = 1'b0;
        req_n = 1'b1;
        gnt_n = 1'b1;
    end

    // one address phase then n data phases, all timed from the bus clock
    task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr, input logic sel,
            input logic wide, input int n, input logic [63:0] wd [$], input logic [7:0] be,
            output logic [63:0] rd, output logic claimed, output logic ack,
            output logic par);
        int k;
        int w;
        logic got;
        rd = 64'h0;
        claimed = 1'b0;
        ack = 1'b0;
        @(posedge sys_clk) #1;
        req_n = 1'b0;
        @(posedge sys_clk) #1;
        gnt_n = req_n;
        frame_n = gnt_n;
        req64_n = !wide;
        idsel = sel;
        m_oe = 1'b1;
        m_ad = {$urandom(), addr};
        cbe_n_in = {4'($urandom()), cmd};
        for (k = 0; k < n; k++) begin
            if (k == 0)
                @(posedge sys_clk);
            #1;
            m_oe = cmd[0];
            if (cmd[0])
                m_ad = wide ? wd[k] : {$urandom(), wd[k][31:0]};
            cbe_n_in = wide ? ~be : {4'($urandom()), ~be[3:0]};
            irdy_n = 1'b0;
            frame_n = (k == n - 1);
            req64_n = wide ? frame_n : 1'b1;
            got = 1'b0;
            for (w = 0; w < 40 && !got; w++) begin
                @(posedge sys_clk);
                if (!(devsel_oe_n | devsel_n_out))
                    claimed = 1'b1;
                if (!(ack64_oe_n | ack64_n_out))
                    ack = 1'b1;
                got = !(trdy_oe_n | trdy_n_out);
                if (w == 4 && !claimed)
                    w = 40;
            end
            if (!got)
                break;
            rd = ad_in;
        end
        #1;
        frame_n = 1'b1;
        irdy_n = 1'b1;
        req64_n = 1'b1;
        idsel = 1'b0;
        m_oe = 1'b0;
        req_n = 1'b1;
        gnt_n = 1'b1;
        @(posedge sys_clk);
        par = par_oe_n ? 1'bx : par_out;
        repeat (3) @(posedge sys_clk);
    endtask
endmodule

// [verification/testbench.sv]
`timescale 1ns/1ps

module testbench;
    import pci_agent_pkg::*;
    logic sys_clk, nrst, frame_n, irdy_n, idsel, req64_n, wr_ready, wr_valid, mem_enable;
    logic [63:0] ad_in, ad_out, wr_data, rd;
    logic [7:0] cbe_n_in, wr_be;
    logic ad_lo_oe_n, ad_hi_oe_n, devsel_n_out, devsel_oe_n, trdy_n_out, trdy_oe_n;
    logic ack64_n_out, ack64_oe_n, par_out, par_oe_n, par64_out, par64_oe_n;
    logic claimed, ack, par, pop_en;
    logic [35:0] hi_prev;
    logic [71:0] exp_q [$];
    int err_count, cmp_count, cnt, cyc;
    logic [3:0] wcmds [2] = '{CMD_MEM_WR, CMD_MEM_WR_INV};
    logic [3:0] rcmds [3] = '{CMD_MEM_RD, CMD_MEM_RD_MULT, CMD_MEM_RD_LINE};

    pci_target DUT (.sys_clk(sys_clk), .nrst(nrst), .frame_n(frame_n), .irdy_n(irdy_n),
        .idsel(idsel), .req64_n(req64_n), .ad_in(ad_in), .cbe_n_in(cbe_n_in),
        .ad_out(ad_out), .ad_lo_oe_n(ad_lo_oe_n), .ad_hi_oe_n(ad_hi_oe_n),
        .devsel_n_out(devsel_n_out), .devsel_oe_n(devsel_oe_n), .trdy_n_out(trdy_n_out),
        .trdy_oe_n(trdy_oe_n), .ack64_n_out(ack64_n_out), .ack64_oe_n(ack64_oe_n),
        .par_out(par_out), .par_oe_n(par_oe_n), .par64_out(par64_out),
        .par64_oe_n(par64_oe_n), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_data(wr_data), .wr_be(wr_be), .mem_enable(mem_enable));

    pci_master_model M (.sys_clk(sys_clk), .frame_n(frame_n), .irdy_n(irdy_n),
        .idsel(idsel), .req64_n(req64_n), .ad_in(ad_in), .cbe_n_in(cbe_n_in),
        .ad_out(ad_out), .ad_lo_oe_n(ad_lo_oe_n), .ad_hi_oe_n(ad_hi_oe_n),
        .devsel_n_out(devsel_n_out), .devsel_oe_n(devsel_oe_n), .trdy_n_out(trdy_n_out),
        .trdy_oe_n(trdy_oe_n), .ack64_n_out(ack64_n_out), .ack64_oe_n(ack64_oe_n),
        .par_out(par_out), .par_oe_n(par_oe_n));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        if (err_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    function automatic logic [63:0] rnd64();
        return {$urandom(), $urandom()};
    endfunction

    function automatic logic [31:0] maddr();
        return MEM_BASE_DEF | {20'h0, 12'($urandom()) & 12'hFFC};
    endfunction

    // hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            test_done();
        end
    end

    // upper parity watch: even over upper lanes and enables of the previous clock
    always @(posedge sys_clk) begin
        if (par64_oe_n === 1'b0)
            check("par64", 64'(par64_out), 64'(^hi_prev));
        hi_prev = {ad_in[63:32], cbe_n_in[7:4]};
    end

    // user side of the write fifo, stalling at random
    always @(posedge sys_clk) begin
        if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
            check("wr_data", wr_data, exp_q[0][63:0]);
            check("wr_be", 64'(wr_be), 64'(exp_q[0][71:64]));
            void'(exp_q.pop_front());
        end
        #1 wr_ready = pop_en & ($urandom_range(0, 3) != 0);
    end

    // one transaction with its expectations
    task automatic run(input logic [3:0] cmd, input logic [31:0] a, input logic sel,
            input logic wide, input int n, input logic [63:0] d0, input logic hit);
        logic [63:0] wd [$];
        logic [7:0] be;
        logic mw;
        int i;
        be = wide ? 8'($urandom()) : {4'h0, 4'($urandom())};
        be[0] = be[0] | (cmd == CMD_CFG_WR); // control byte always enabled
        mw = hit && cmd[0] && cmd != CMD_CFG_WR;
        for (i = 0; i < n; i++) begin
            wd.push_back(i == 0 ? d0 : rnd64());
            if (mw)
                exp_q.push_back({be, wide ? wd[i] : {32'h0, wd[i][31:0]}});
        end
        M.xfer(cmd, a, sel, wide, n, wd, be, rd, claimed, ack, par);
        check("claimed", 64'(claimed), 64'(hit));
        if (hit)
            check("ack64", 64'(ack), 64'(wide && cmd[3:1] != 3'h5));
        if (hit && !cmd[0])
            check("par", 64'(par), 64'(^{rd[31:0], ~be[3:0]}));
        if (mw)
            cnt += n;
    endtask

    initial begin
        nrst = 1'b0;
        wr_ready = 1'b0;
        pop_en = 1'b0;
        void'($urandom(32'hE9320A99));
        repeat (6) @(posedge sys_clk);
        check("reset_outs", 64'({ad_lo_oe_n, ad_hi_oe_n, devsel_oe_n, trdy_oe_n,
            ack64_oe_n, par_oe_n, wr_valid, mem_enable}), 64'h FC);
        repeat (6) @(posedge sys_clk);
        #1 nrst = 1'b1;
        run(CMD_MEM_WR, maddr(), 1'b0, 1'b0, 1, rnd64(), 1'b0);
        run(CMD_CFG_WR, {24'h0, CFG_IDX_CTRL, 2'b00}, 1'b0, 1'b0, 1, 64'h2, 1'b0);
        check("mem_enable", 64'(mem_enable), 64'h0);
        run(CMD_CFG_WR, {24'h0, CFG_IDX_CTRL, 2'b00}, 1'b1, 1'b0, 1, 64'h2, 1'b1);
        check("mem_enable", 64'(mem_enable), 64'h1);
        run(CMD_CFG_RD, {24'h0, CFG_IDX_ID, 2'b00}, 1'b1, 1'b0, 1, 64'h0, 1'b1);
        check("cfg_id", 64'(rd[31:0]), 64'(CFG_ID_VALUE));
        run(CMD_CFG_RD, {24'h0, CFG_IDX_CTRL, 2'b00}, 1'b1, 1'b0, 1, 64'h0, 1'b1);
        check("cfg_ctrl", 64'(rd[31:0]), 64'h2);
        pop_en = 1'b1;
        for (int r = 0; r < 3; r++) begin
            foreach (wcmds[c])
                for (int w = 0; w < 2; w++)
                    run(wcmds[c], maddr(), 1'b0, w[0], 1 + $urandom_range(0, 2), rnd64(),
                        1'b1);
            foreach (rcmds[c])
                for (int w = 0; w < 2; w++) begin
                    run(rcmds[c], maddr(), 1'b0, w[0], 1, 64'h0, 1'b1);
                    check("rd_lo", 64'(rd[31:0]), 64'(cnt));
                    if (w == 1)
                        check("rd_hi", 64'(rd[63:32]), 64'(cnt));
                end
        end
        run(CMD_MEM_WR, MEM_BASE_DEF ^ 32'h1000, 1'b0, 1'b0, 1, rnd64(), 1'b0);
        run(4'hD, maddr(), 1'b0, 1'b1, 1, rnd64(), 1'b0);
        run(4'h2, maddr(), 1'b0, 1'b0, 1, rnd64(), 1'b0);
        pop_en = 1'b0;
        fork
            run(CMD_MEM_WR, maddr(), 1'b0, 1'b1, 6, rnd64(), 1'b1);
            begin
                repeat (30) @(posedge sys_clk);
                pop_en = 1'b1;
            end
        join
        run(CMD_MEM_RD, maddr(), 1'b1, 1'b0, 1, 64'h0, 1'b1);
        check("rd_count", 64'(rd[31:0]), 64'(cnt));
        repeat (20) @(posedge sys_clk);
        check("fifo_left", 64'(exp_q.size()), 64'h0);
        test_done();
    end
endmodule
